// >>> pkg/rss_pkg.sv
// Shared constants and types for the relay scan and status unit
package rss_pkg;
  // ==========================================================
  // Sizes
  localparam int unsigned CHANNELS     = 32;
  localparam int unsigned LIST_DEPTH   = 128;
  localparam logic [6:0]  CARD_DEFAULT = 7'h01;
  // ==========================================================
  // Channel address layout in command data
  localparam int unsigned CARD_LSB = 8;
  localparam int unsigned CHAN_LSB = 0;
  localparam int unsigned LINE_LSB = 4;
  // ==========================================================
  // Status bit positions
  localparam int unsigned EV_SCAN_DONE = 8;
  localparam int unsigned STB_OPR      = 7;
  localparam int unsigned STB_RQS      = 6;
  localparam int unsigned STB_ESB      = 5;
  localparam int unsigned STB_MAV      = 4;
  localparam int unsigned STB_QUE      = 3;
  localparam logic [15:0] OPER_COND_VALUE = 16'h0000;
  localparam logic [15:0] OPER_EN_RESET   = 16'h0000;
  localparam logic [7:0]  STD_EN_RESET    = 8'h00;
  // ==========================================================
  // Trigger output pulse
  localparam int unsigned CLK_PERIOD_PS   = 5000;
  localparam int unsigned TRIG_PULSE_NS   = 1000;
  localparam int unsigned TRIG_PULSE_CYC  = (TRIG_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // ==========================================================
  // Commands
  typedef enum logic [4:0] {
    RSS_NOP = 5'h00, RSS_OPEN_Q = 5'h01, RSS_CLOSE_Q = 5'h02, RSS_SCAN_BEGIN = 5'h03,
    RSS_SCAN_ADD = 5'h04, RSS_INIT = 5'h05, RSS_ABORT = 5'h06, RSS_TRIG = 5'h07,
    RSS_TRIG_SRC = 5'h08, RSS_OUT_SEL = 5'h09, RSS_OPER_EN_W = 5'h0a, RSS_OPER_EN_R = 5'h0b,
    RSS_OPER_EV_R = 5'h0c, RSS_OPER_COND_R = 5'h0d, RSS_STB_R = 5'h0e, RSS_STAT_PRESET = 5'h0f,
    RSS_STD_EN_W = 5'h10, RSS_STD_EN_R = 5'h11
  } rss_op_t;
  typedef enum logic [2:0] {
    SRC_BUS = 3'h0, SRC_EXT = 3'h1, SRC_HOLD = 3'h2, SRC_IMM = 3'h3, SRC_TTL = 3'h4
  } rss_src_t;
  typedef enum logic [1:0] {
    OUT_OFF = 2'h0, OUT_EXT = 2'h1, OUT_TTL = 2'h2
  } rss_out_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01, ST_RUN = 2'b10
  } rss_state_t;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic        valid;
    rss_op_t     op;
    logic [15:0] data;
  } rss_cmd_t;
  typedef struct packed {
    logic        valid;
    logic        error;
    logic [15:0] data;
  } rss_rsp_t;
endpackage : rss_pkg

// >>> rtl/rss_top.sv
// Relay scan and status unit: relay state, scan sequencing, operation status
`timescale 1ns/100ps
module rss_top
  import rss_pkg::*;
#(
  parameter int unsigned DEPTH     = rss_pkg::LIST_DEPTH,
  parameter logic [6:0]  CARD_NUM  = rss_pkg::CARD_DEFAULT,
  parameter int unsigned PULSE_CYC = rss_pkg::TRIG_PULSE_CYC
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // Command and answer
  input  wire rss_pkg::rss_cmd_t cmd,
  output rss_pkg::rss_rsp_t     rsp,
  // Status inputs from the command module
  input  wire logic [7:0]       std_event,
  input  wire logic             msg_avail,
  input  wire logic             quest_data,
  input  wire logic             svc_request,
  // Trigger pins
  input  wire logic             ext_trig_in_n,
  input  wire logic [7:0]       ttl_trig_in_n,
  output logic                  ext_trig_out_n,
  output logic [7:0]            ttl_trig_o,
  output logic [7:0]            ttl_trig_oe,
  // Relays and status
  output logic [31:0]           relay_closed,
  output logic [7:0]            status_byte,
  output logic                  scanning
);
  import rss_pkg::*;

  localparam int unsigned IW = $clog2(DEPTH);
  localparam int unsigned PW = $clog2(PULSE_CYC + 1);

  // ==========================================================
  // Reset release
  logic rst_s1, rst_n;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // ==========================================================
  // Trigger input synchronisers and edge detect
  logic [8:0] tin_s1, tin_s2, tin_s3;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tin_s1 <= 9'h1ff;
      tin_s2 <= 9'h1ff;
      tin_s3 <= 9'h1ff;
    end else begin
      tin_s1 <= {ext_trig_in_n, ttl_trig_in_n};
      tin_s2 <= tin_s1;
      tin_s3 <= tin_s2;
    end
  end
  logic [8:0] tin_fall;
  assign tin_fall = tin_s3 & ~tin_s2;

  // ==========================================================
  // Command decode
  logic [6:0] q_card, q_chan;
  logic       addr_ok;
  assign q_card = cmd.data[CARD_LSB +: 7];
  assign q_chan = cmd.data[CHAN_LSB +: 7];
  assign addr_ok = (q_card == CARD_NUM) && (q_chan < 7'(CHANNELS));

  logic is_init, is_abort, is_trig, is_add, is_begin;
  assign is_init  = cmd.valid && cmd.op == RSS_INIT;
  assign is_abort = cmd.valid && cmd.op == RSS_ABORT;
  assign is_trig  = cmd.valid && cmd.op == RSS_TRIG;
  assign is_add   = cmd.valid && cmd.op == RSS_SCAN_ADD;
  assign is_begin = cmd.valid && cmd.op == RSS_SCAN_BEGIN;

  // ==========================================================
  // Trigger source and output selection
  rss_src_t   trig_src;
  logic [2:0] trig_line;
  rss_out_t   out_sel;
  logic [2:0] out_line;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_src  <= SRC_IMM;
      trig_line <= 3'h0;
      out_sel   <= OUT_OFF;
      out_line  <= 3'h0;
    end else if (cmd.valid && cmd.op == RSS_TRIG_SRC && cmd.data[2:0] <= 3'(SRC_TTL)) begin
      trig_src  <= rss_src_t'(cmd.data[2:0]);
      trig_line <= cmd.data[LINE_LSB +: 3];
    end else if (cmd.valid && cmd.op == RSS_OUT_SEL && cmd.data[1:0] != 2'h3) begin
      out_sel   <= rss_out_t'(cmd.data[1:0]);
      out_line  <= cmd.data[LINE_LSB +: 3];
    end
  end

  // ==========================================================
  // Scan list storage
  logic [4:0]  list_mem [DEPTH];
  logic [IW:0] list_len;
  logic        list_ok;
  logic        add_bad;
  assign add_bad = is_add && (!addr_ok || list_len == (IW+1)'(DEPTH));
  always_ff @(posedge clk) begin
    if (is_add && !add_bad)
      list_mem[list_len[IW-1:0]] <= q_chan[4:0];
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      list_len <= '0;
      list_ok  <= 1'b0;
    end else if (is_begin) begin
      list_len <= '0;
      list_ok  <= 1'b1;
    end else if (is_add) begin
      if (add_bad)
        list_ok <= 1'b0;
      else
        list_len <= list_len + (IW+1)'(1);
    end
  end

  // ==========================================================
  // Scan sequencer
  rss_state_t  state;
  logic [IW:0] idx;
  logic        can_start, trig_fire, last_hit, scan_done, closed_evt;
  assign can_start = is_init && state == ST_IDLE && list_ok && list_len != '0;
  always_comb begin
    case (trig_src)
      SRC_BUS, SRC_HOLD: trig_fire = is_trig;
      SRC_EXT:           trig_fire = tin_fall[8];
      SRC_IMM:           trig_fire = 1'b1;
      SRC_TTL:           trig_fire = tin_fall[trig_line];
      default:           trig_fire = 1'b0;
    endcase
  end
  assign last_hit  = (idx + (IW+1)'(1)) == list_len;
  assign scan_done = state == ST_RUN && trig_fire && !is_abort && last_hit;
  assign closed_evt = can_start || (state == ST_RUN && trig_fire && !is_abort && !last_hit);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state        <= ST_IDLE;
      idx          <= '0;
      relay_closed <= 32'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (can_start) begin
            state        <= ST_RUN;
            idx          <= '0;
            relay_closed <= 32'h1 << list_mem[0];
          end
        end
        ST_RUN: begin
          if (is_abort) begin
            state        <= ST_IDLE;
            relay_closed <= 32'h0;
          end else if (scan_done) begin
            state        <= ST_IDLE;
            relay_closed <= 32'h0;
          end else if (trig_fire) begin
            idx          <= idx + (IW+1)'(1);
            relay_closed <= 32'h1 << list_mem[idx[IW-1:0] + IW'(1)];
          end
        end
        default: begin
          state        <= ST_IDLE;
          relay_closed <= 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      scanning <= 1'b0;
    else
      scanning <= (state == ST_RUN && !is_abort && !scan_done) || can_start;
  end

  // ==========================================================
  // Trigger output pulse
  logic [PW-1:0] pulse_cnt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      pulse_cnt <= '0;
    else if (closed_evt && out_sel != OUT_OFF)
      pulse_cnt <= PW'(PULSE_CYC);
    else if (pulse_cnt != '0)
      pulse_cnt <= pulse_cnt - PW'(1);
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_trig_out_n <= 1'b1;
      ttl_trig_o     <= 8'h00;
      ttl_trig_oe    <= 8'h00;
    end else begin
      ext_trig_out_n <= !(closed_evt && out_sel == OUT_EXT) && !(pulse_cnt > PW'(1) && out_sel == OUT_EXT);
      ttl_trig_o     <= 8'h00;
      ttl_trig_oe    <= ((closed_evt || pulse_cnt > PW'(1)) && out_sel == OUT_TTL) ? (8'h01 << out_line) : 8'h00;
    end
  end

  // ==========================================================
  // Operation status registers
  logic [15:0] oper_en, oper_ev;
  logic [7:0]  std_en;
  logic        ev_read;
  assign ev_read = cmd.valid && cmd.op == RSS_OPER_EV_R;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      oper_en <= OPER_EN_RESET;
    else if (cmd.valid && cmd.op == RSS_OPER_EN_W)
      oper_en <= cmd.data;
    else if (cmd.valid && cmd.op == RSS_STAT_PRESET)
      oper_en <= OPER_EN_RESET;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      std_en <= STD_EN_RESET;
    else if (cmd.valid && cmd.op == RSS_STD_EN_W)
      std_en <= cmd.data[7:0];
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      oper_ev <= 16'h0;
    else if (scan_done)
      oper_ev <= 16'h1 << EV_SCAN_DONE;
    else if (ev_read)
      oper_ev <= 16'h0;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      status_byte <= 8'h00;
    else begin
      status_byte          <= 8'h00;
      status_byte[STB_OPR] <= |(oper_ev & oper_en);
      status_byte[STB_RQS] <= svc_request;
      status_byte[STB_ESB] <= |(std_event & std_en);
      status_byte[STB_MAV] <= msg_avail;
      status_byte[STB_QUE] <= quest_data;
    end
  end

  // ==========================================================
  // Answers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      rsp <= '0;
    else begin
      rsp.valid <= cmd.valid;
      rsp.error <= 1'b0;
      rsp.data  <= 16'h0;
      if (cmd.valid) begin
        case (cmd.op)
          RSS_OPEN_Q: begin
            rsp.error <= !addr_ok;
            rsp.data  <= {15'h0, addr_ok && !relay_closed[q_chan[4:0]]};
          end
          RSS_CLOSE_Q: begin
            rsp.error <= !addr_ok;
            rsp.data  <= {15'h0, addr_ok && relay_closed[q_chan[4:0]]};
          end
          RSS_SCAN_ADD:    rsp.error <= add_bad;
          RSS_INIT:        rsp.error <= !can_start;
          RSS_OPER_EN_R:   rsp.data  <= oper_en;
          RSS_OPER_EV_R:   rsp.data  <= oper_ev;
          RSS_OPER_COND_R: rsp.data  <= OPER_COND_VALUE;
          RSS_STB_R:       rsp.data  <= {8'h00, status_byte};
          RSS_STD_EN_R:    rsp.data  <= {8'h00, std_en};
          default:         rsp.error <= 1'b0;
        endcase
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_INIT_CLOSES_FIRST: assert property (can_start |=> relay_closed == (32'h1 << list_mem[0]) && scanning)
    else $error("initiate did not close first channel");
  AST_RUN_ONE_CLOSED: assert property (state == ST_RUN |-> $onehot(relay_closed))
    else $error("scan not holding exactly one channel");
  AST_DONE_OPENS_ALL: assert property (scan_done |=> relay_closed == 32'h0 && oper_ev[EV_SCAN_DONE])
    else $error("scan end left a channel closed or no event");
  AST_EVENT_CLEARED: assert property (ev_read && !scan_done |=> oper_ev == 16'h0)
    else $error("event read did not clear");
  AST_ABORT_NO_EVENT: assert property (is_abort && !oper_ev[EV_SCAN_DONE] |=> !oper_ev[EV_SCAN_DONE])
    else $error("abort set scan complete");
  AST_OPR_SUMMARY: assert property (oper_ev[EV_SCAN_DONE] && oper_en[EV_SCAN_DONE] |=> status_byte[STB_OPR])
    else $error("enabled scan complete not summarised");
  AST_PRESET_MASK: assert property (cmd.valid && cmd.op == RSS_STAT_PRESET && !scan_done
                                    |=> oper_en == 16'h0 && $stable(oper_ev))
    else $error("preset misbehaved");
  AST_OPEN_QUERY: assert property (cmd.valid && cmd.op == RSS_OPEN_Q && addr_ok
                                   |=> rsp.valid && rsp.data[0] == !$past(relay_closed[q_chan[4:0]]))
    else $error("open query answer wrong");
  AST_BAD_ENTRY: assert property (is_add && !addr_ok |=> rsp.error && !list_ok)
    else $error("invalid entry not flagged");
  AST_TRIG_OUT: assert property (closed_evt && out_sel == OUT_EXT |=> !ext_trig_out_n [*2])
    else $error("trigger output pulse missing");

  COV_FULL_SCAN: cover property (can_start ##[1:20] scan_done);
  COV_ABORT: cover property (state == ST_RUN && is_abort);
  COV_EVENT_READ: cover property (oper_ev[EV_SCAN_DONE] ##1 ev_read);
endmodule : rss_top

// >>> dv/rss_host.sv
// Host controller model driving the command port
`timescale 1ns/100ps
module rss_host (
  // Clock
  input  wire logic         clk,
  // Command out
  output rss_pkg::rss_cmd_t cmd
);
  import rss_pkg::*;
  logic [15:0] idle_pat = 16'h5a5a;
  initial cmd = '0;
  // ==========================================================
  // Command strobe, one cycle per command
  // one channel per query
  task automatic issue(input rss_op_t op, input logic [15:0] data);
    cmd = '{valid: 1'b1, op: op, data: data};
    @(posedge clk);
    #1;
  endtask : issue
  // Idle data flips so stale values never look valid
  task automatic idle();
    idle_pat = ~idle_pat;
    cmd = '{valid: 1'b0, op: RSS_NOP, data: idle_pat};
    @(posedge clk);
    #1;
  endtask : idle
  function automatic logic [15:0] chan(input logic [6:0] card, input logic [6:0] ch);
    return {1'b0, card, 1'b0, ch};
  endfunction : chan
endmodule : rss_host

// >>> dv/testbench.sv
// Self-checking testbench for the relay scan and status unit
`timescale 1ns/100ps
module testbench;
  import rss_pkg::*;
  localparam int unsigned PULSE = 4;
  localparam logic [6:0]  CARD  = 7'h01;
  logic        clk           = 1'b0;
  logic        arst_n        = 1'b0;
  rss_cmd_t    cmd;
  rss_rsp_t    rsp;
  logic [7:0]  std_event     = 8'h00;
  logic        msg_avail     = 1'b0;
  logic        quest_data    = 1'b0;
  logic        svc_request   = 1'b0;
  logic        ext_trig_in_n = 1'b1;
  logic [7:0]  ttl_drv_n     = 8'hff;
  logic        ext_trig_out_n;
  logic [7:0]  ttl_trig_o;
  logic [7:0]  ttl_trig_oe;
  wire  [7:0]  ttl_wire_n    = ttl_drv_n & ~ttl_trig_oe;
  logic [7:0]  status_byte;
  logic [31:0] relay_closed;
  logic        scanning;
  int          err_total     = 0;
  int          checks        = 0;
  logic [16:0] lfsr          = 17'd72424;
  logic [16:0] exp_q[$];
  logic [6:0]  list[3];
  logic [15:0] r;
  rss_src_t    srcs[5]       = '{SRC_HOLD, SRC_BUS, SRC_EXT, SRC_TTL, SRC_IMM};
  initial begin
    forever #2.5 clk = ~clk;
  end
  rss_host host_u (.clk(clk), .cmd(cmd));
  rss_top #(.DEPTH(LIST_DEPTH), .CARD_NUM(CARD), .PULSE_CYC(PULSE)) dut_u (
    .clk(clk), .arst_n(arst_n), .cmd(cmd), .rsp(rsp), .std_event(std_event),
    .msg_avail(msg_avail), .quest_data(quest_data), .svc_request(svc_request),
    .ext_trig_in_n(ext_trig_in_n), .ttl_trig_in_n(ttl_wire_n), .ext_trig_out_n(ext_trig_out_n),
    .ttl_trig_o(ttl_trig_o), .ttl_trig_oe(ttl_trig_oe), .relay_closed(relay_closed),
    .status_byte(status_byte), .scanning(scanning));
  // ==========================================================
  // Helpers
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[15:0], lfsr[16] ^ lfsr[13]};
    return lfsr[15:0];
  endfunction : rnd
  task automatic cmp_val(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_val
  task automatic cmp_rsp(input logic [16:0] got, input logic [16:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t rsp got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_rsp
  task automatic send(input rss_op_t op, input logic [15:0] d, input logic e, input logic [15:0] x);
    exp_q.push_back({e, x});
    host_u.issue(op, d);
  endtask : send
  task automatic final_report();
    if (exp_q.size() != 0) err_total++;
    $display("Counts: checks=%0d mismatches=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  task automatic wait_idle();
    for (int i = 0; i < 300; i++) begin
      if (scanning === 1'b0) return;
      host_u.idle();
    end
    err_total++;
    final_report();
  endtask : wait_idle
  task automatic fire(input rss_src_t s);
    if (s == SRC_EXT) ext_trig_in_n = 1'b0;
    else if (s == SRC_TTL) ttl_drv_n[2] = 1'b0;
    else send(RSS_TRIG, 16'h0000, 1'b0, 16'h0000);
    repeat (4) host_u.idle();
    ext_trig_in_n = 1'b1;
    ttl_drv_n = 8'hff;
    repeat (2) host_u.idle();
  endtask : fire
  // ==========================================================
  // Answer monitor
  always @(posedge clk) begin
    if (arst_n === 1'b1 && rsp.valid !== 1'b0) begin
      if (exp_q.size() > 0) begin
        cmp_rsp({rsp.error, rsp.data}, exp_q.pop_front());
      end else begin
        err_total++;
        $display("ERROR t=%0t unexpected rsp got=%h exp=%h", $time, {rsp.error, rsp.data}, 17'h00000);
      end
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    cmp_val(relay_closed, 32'h0);
    cmp_val({scanning, ext_trig_out_n, status_byte}, {1'b0, 1'b1, 8'h00});
    send(RSS_OPER_COND_R, 16'h0000, 1'b0, 16'h0000);
    send(RSS_OPEN_Q, host_u.chan(CARD, 7'd31), 1'b0, 16'h0001);
    send(RSS_OPEN_Q, host_u.chan(CARD, 7'd32), 1'b1, 16'h0000);
    send(RSS_CLOSE_Q, host_u.chan(7'h02, 7'd3), 1'b1, 16'h0000);
    r = rnd();
    send(RSS_OPER_EN_W, r, 1'b0, 16'h0000);
    send(RSS_OPER_EN_R, 16'h0000, 1'b0, r);
    send(RSS_OPER_EN_W, 16'h0100, 1'b0, 16'h0000);
    send(RSS_OUT_SEL, 16'h0001, 1'b0, 16'h0000);
    host_u.idle();
    $display("test reset_query done");
    for (int s = 0; s < 5; s++) begin
      send(RSS_TRIG_SRC, {12'h002, 1'b0, srcs[s]}, 1'b0, 16'h0000);
      send(RSS_SCAN_BEGIN, 16'h0000, 1'b0, 16'h0000);
      foreach (list[i]) begin
        list[i] = 7'(rnd() % 16'd32);
        send(RSS_SCAN_ADD, host_u.chan(CARD, list[i]), 1'b0, 16'h0000);
      end
      send(RSS_INIT, 16'h0000, 1'b0, 16'h0000);
      host_u.idle();
      if (s == 0) begin
        cmp_val(ext_trig_out_n, 32'h0);
        send(RSS_OPEN_Q, host_u.chan(CARD, list[0]), 1'b0, 16'h0000);
        send(RSS_CLOSE_Q, host_u.chan(CARD, list[0]), 1'b0, 16'h0001);
        send(RSS_INIT, 16'h0000, 1'b1, 16'h0000);
        host_u.idle();
      end
      if (srcs[s] == SRC_IMM) wait_idle();
      else begin
        foreach (list[i]) begin
          cmp_val(relay_closed, 32'h1 << list[i]);
          fire(srcs[s]);
        end
      end
      cmp_val({scanning, relay_closed}, 32'h0);
      host_u.idle();
      cmp_val(status_byte[STB_OPR], s == 0);
      if (s == 0) begin
        send(RSS_STAT_PRESET, 16'h0000, 1'b0, 16'h0000);
        send(RSS_OPER_EN_R, 16'h0000, 1'b0, 16'h0000);
      end
      send(RSS_OPER_EV_R, 16'h0000, 1'b0, 16'h0100);
      send(RSS_OPER_EV_R, 16'h0000, 1'b0, 16'h0000);
      host_u.idle();
      $display("test scan source %0d done", s);
    end
    send(RSS_OUT_SEL, 16'h0062, 1'b0, 16'h0000);
    send(RSS_TRIG_SRC, {13'h0000, SRC_HOLD}, 1'b0, 16'h0000);
    send(RSS_SCAN_BEGIN, 16'h0000, 1'b0, 16'h0000);
    send(RSS_SCAN_ADD, host_u.chan(CARD, 7'd4), 1'b0, 16'h0000);
    send(RSS_SCAN_ADD, host_u.chan(CARD, 7'd0), 1'b0, 16'h0000);
    send(RSS_INIT, 16'h0000, 1'b0, 16'h0000);
    host_u.idle();
    cmp_val({ttl_trig_oe, ttl_trig_o}, 32'h4000);
    send(RSS_ABORT, 16'h0000, 1'b0, 16'h0000);
    host_u.idle();
    cmp_val({scanning, relay_closed}, 32'h0);
    send(RSS_OPER_EV_R, 16'h0000, 1'b0, 16'h0000);
    send(RSS_SCAN_BEGIN, 16'h0000, 1'b0, 16'h0000);
    send(RSS_SCAN_ADD, host_u.chan(CARD, 7'd40), 1'b1, 16'h0000);
    send(RSS_INIT, 16'h0000, 1'b1, 16'h0000);
    send(RSS_SCAN_BEGIN, 16'h0000, 1'b0, 16'h0000);
    send(RSS_SCAN_ADD, host_u.chan(7'h02, 7'd3), 1'b1, 16'h0000);
    host_u.idle();
    cmp_val(relay_closed, 32'h0);
    $display("test abort_list done");
    repeat (4) begin
      r = rnd();
      std_event = r[7:0];
      {msg_avail, quest_data, svc_request} = r[10:8];
      send(RSS_STD_EN_W, {8'h00, r[15:8]}, 1'b0, 16'h0000);
      send(RSS_STD_EN_R, 16'h0000, 1'b0, {8'h00, r[15:8]});
      repeat (2) host_u.idle();
      cmp_val(status_byte, {1'b0, r[8], |(r[7:0] & r[15:8]), r[10], r[9], 3'h0});
    end
    $display("test status_byte done");
    final_report();
  end
endmodule : testbench
